// File: src/hrm_monitor.sv
// Reference selection, ratio check, validity flag and tuning hold.
// Contract
// - choice 1 picks first reference, 0 second.
// - ratio code 00 bypasses oscillator and PLL.
// - codes set ratio 1/2, 2, 6.
// - PLL always fed from crystal only.
// - valid flag high only while reference good.
// - stopped reference freezes tuning, flags failure.
// - tune only while scaled reference in range.
// - out of range fails, return clears failure.
// - fail within 2 periods, recover after 12; at ratio 1/2 the code waits 3 crystal periods to fail.
// - resume alignment automatically after recovery.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
module hrm_monitor
    import hrm_pkg::*;
#(
    parameter int WIN_XTAL = 16,
    parameter int TOL_EDGES = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ref_a_in,
    input wire logic ref_b_in,
    input wire logic crystal_in,
    input wire logic pll_clk_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic pll_ref_out,
    output logic [1:0] bank_a_outputs,
    output logic [1:0] bank_b_outputs,
    output logic ref_valid,
    output logic [TUNE_W-1:0] tune_word,
    output logic irq
);
    logic [2:0] lvl, rse;
    logic ref_lvl, ref_rise, xtal_lvl, xtal_rise;

    hrm_sync3 #(.W(3)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in({crystal_in, ref_b_in, ref_a_in}),
        .level(lvl),
        .rise(rse)
    );

    // Registers.
    logic [2:0] ctrl_ff, nxt_ctrl;
    logic [1:0] ist_ff, nxt_ist, imask_ff, nxt_imask;
    logic [1:0] ratio;
    assign ratio = ctrl_ff[CTRL_RATIO_LSB +: 2];

    assign ref_lvl = ctrl_ff[CTRL_CHOICE_BIT] ? lvl[0] : lvl[1];
    assign ref_rise = ctrl_ff[CTRL_CHOICE_BIT] ? rse[0] : rse[1];
    assign xtal_lvl = lvl[2];
    assign xtal_rise = rse[2];

    // Expected reference edges in a window of WIN_XTAL crystal edges.
    function automatic logic [11:0] expect_edges(input logic [1:0] code);
        case (code)
            RATIO_HALF: expect_edges = 12'(WIN_XTAL / 2);
            RATIO_TWO: expect_edges = 12'(WIN_XTAL * 2);
            RATIO_SIX: expect_edges = 12'(WIN_XTAL * 6);
            default: expect_edges = 12'h0000;
        endcase
    endfunction : expect_edges

    // Crystal edges without a reference edge before the stall is declared.
    function automatic logic [3:0] stall_limit(input logic [1:0] code);
        if (code == RATIO_HALF) begin
            stall_limit = 4'(FAIL_XTAL_PERIODS + 1);
        end else begin
            stall_limit = 4'(FAIL_XTAL_PERIODS);
        end
    endfunction : stall_limit

    // Frequency window and stall detection.
    logic [7:0] win_ff, nxt_win;
    logic [11:0] rcnt_ff, nxt_rcnt;
    logic in_range_ff, nxt_in_range;
    logic [3:0] stall_ff, nxt_stall;
    logic win_end, stalled, good;
    logic [11:0] exp_n;

    assign exp_n = expect_edges(ratio);
    assign win_end = xtal_rise && (win_ff == 8'(WIN_XTAL - 1));
    assign stalled = stall_ff >= stall_limit(ratio);
    assign good = !stalled && in_range_ff;

    always_comb begin
        nxt_win = win_ff;
        nxt_rcnt = rcnt_ff;
        nxt_in_range = in_range_ff;
        nxt_stall = stall_ff;
        if (xtal_rise) begin
            nxt_win = win_end ? 8'h00 : 8'(win_ff + 8'h01);
        end
        if (win_end) begin
            nxt_rcnt = {11'h000, ref_rise};
            nxt_in_range = (ratio == RATIO_BYPASS) ||
                ((rcnt_ff + 12'(TOL_EDGES) >= exp_n) &&
                 (rcnt_ff <= exp_n + 12'(TOL_EDGES)));
        end else if (ref_rise) begin
            nxt_rcnt = rcnt_ff + 12'h001;
        end
        if (ref_rise) begin
            nxt_stall = 4'h0;
        end else if (xtal_rise && !stalled) begin
            nxt_stall = stall_ff + 4'h1;
        end
    end

    // Validity state machine.
    hrm_state_e st_ff, nxt_st;
    logic [3:0] rec_ff, nxt_rec;
    logic [TUNE_W-1:0] tune_ff, nxt_tune;
    logic fail_ev, rec_ev;

    always_comb begin
        nxt_st = st_ff;
        nxt_rec = rec_ff;
        fail_ev = 1'b0;
        rec_ev = 1'b0;
        case (st_ff)
            HRM_VALID: begin
                if (!good) begin
                    nxt_st = HRM_FAILED;
                    fail_ev = 1'b1;
                end
            end
            HRM_FAILED: begin
                if (good) begin
                    nxt_st = HRM_RECOVER;
                    nxt_rec = 4'h0;
                end
            end
            HRM_RECOVER: begin
                if (!good) begin
                    nxt_st = HRM_FAILED;
                end else if (xtal_rise) begin
                    nxt_rec = rec_ff + 4'h1;
                    // The first edge may come at once, so one edge more
                    // than periods guarantees the whole minimum time.
                    if (rec_ff == 4'(REC_XTAL_PERIODS)) begin
                        nxt_st = HRM_SETTLE;
                        nxt_rec = 4'h0;
                    end
                end
            end
            HRM_SETTLE: begin
                if (!good) begin
                    nxt_st = HRM_FAILED;
                end else if (rec_ff == 4'(REC_EXTRA_CYC - 1)) begin
                    nxt_st = HRM_VALID;
                    rec_ev = 1'b1;
                end else begin
                    nxt_rec = rec_ff + 4'h1;
                end
            end
            default: nxt_st = HRM_FAILED;
        endcase
    end

    // Tuning follows the reference count only while valid; it holds
    // otherwise, which is the holdover behaviour.
    always_comb begin
        nxt_tune = tune_ff;
        if (st_ff == HRM_VALID && good && win_end &&
            ratio != RATIO_BYPASS) begin
            if (rcnt_ff > exp_n && tune_ff != '1) begin
                nxt_tune = tune_ff + TUNE_W'(1);
            end else if (rcnt_ff < exp_n && tune_ff != '0) begin
                nxt_tune = tune_ff - TUNE_W'(1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_ff <= 8'h00;
            rcnt_ff <= 12'h000;
            in_range_ff <= 1'b0;
            stall_ff <= 4'h0;
            st_ff <= HRM_FAILED;
            rec_ff <= 4'h0;
            tune_ff <= TUNE_RESET;
        end else begin
            win_ff <= nxt_win;
            rcnt_ff <= nxt_rcnt;
            in_range_ff <= nxt_in_range;
            stall_ff <= nxt_stall;
            st_ff <= nxt_st;
            rec_ff <= nxt_rec;
            tune_ff <= nxt_tune;
        end
    end

    // Clock outputs.
    logic [2:0] clk_ff, nxt_clk;
    always_comb begin
        nxt_clk[0] = xtal_lvl;
        nxt_clk[1] = (ratio == RATIO_BYPASS) ? ref_lvl : pll_clk_in;
        nxt_clk[2] = (st_ff == HRM_VALID);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_ff <= 3'h0;
        end else begin
            clk_ff <= nxt_clk;
        end
    end

    assign pll_ref_out = clk_ff[0];
    assign bank_a_outputs = {2{clk_ff[1]}};
    assign bank_b_outputs = {2{clk_ff[1]}};
    assign ref_valid = clk_ff[2];
    assign tune_word = tune_ff;

    // AXI4-Lite slave; one write and one read at a time.
    logic aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, rv_ff, nxt_rv;
    logic [7:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
    logic [3:0] ws_ff, nxt_ws;
    logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
    logic do_wr, do_rd;

    assign s_axi_awready = !aw_ff && !bv_ff;
    assign s_axi_wready = !w_ff && !bv_ff;
    assign s_axi_arready = !rv_ff;
    assign do_wr = aw_ff && w_ff && !bv_ff;
    assign do_rd = s_axi_arvalid && !rv_ff;

    always_comb begin
        nxt_aw = aw_ff;
        nxt_w = w_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        nxt_ctrl = ctrl_ff;
        nxt_imask = imask_ff;
        nxt_ist = ist_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw = 1'b1;
            nxt_awa = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w = 1'b1;
            nxt_wd = s_axi_wdata;
            nxt_ws = s_axi_wstrb;
        end
        if (do_wr) begin
            nxt_aw = 1'b0;
            nxt_w = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = RESP_OKAY;
            case (awa_ff)
                ADDR_CTRL: if (ws_ff[0]) nxt_ctrl = wd_ff[2:0];
                ADDR_IRQ_MASK: if (ws_ff[0]) nxt_imask = wd_ff[1:0];
                ADDR_IRQ_STAT: if (ws_ff[0]) nxt_ist = ist_ff & ~wd_ff[1:0];
                ADDR_STATUS, ADDR_TUNE: nxt_br = RESP_OKAY;
                default: nxt_br = RESP_SLVERR;
            endcase
        end
        if (bv_ff && s_axi_bready) begin
            nxt_bv = 1'b0;
        end
        // A new event wins over a clear in the same cycle.
        nxt_ist[IRQ_FAIL_BIT] = nxt_ist[IRQ_FAIL_BIT] | fail_ev;
        nxt_ist[IRQ_RECOVER_BIT] = nxt_ist[IRQ_RECOVER_BIT] | rec_ev;
    end

    always_comb begin
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (rv_ff && s_axi_rready) begin
            nxt_rv = 1'b0;
        end
        if (do_rd) begin
            nxt_rv = 1'b1;
            nxt_rr = RESP_OKAY;
            nxt_rd = 32'h0000_0000;
            case (s_axi_araddr[7:0])
                ADDR_CTRL: nxt_rd[2:0] = ctrl_ff;
                ADDR_STATUS: begin
                    nxt_rd[STAT_VALID_BIT] = (st_ff == HRM_VALID);
                    nxt_rd[STAT_BYPASS_BIT] = (ratio == RATIO_BYPASS);
                end
                ADDR_IRQ_STAT: nxt_rd[1:0] = ist_ff;
                ADDR_IRQ_MASK: nxt_rd[1:0] = imask_ff;
                ADDR_TUNE: nxt_rd[TUNE_W-1:0] = tune_ff;
                default: nxt_rr = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
            bv_ff <= 1'b0;
            br_ff <= 2'h0;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0000_0000;
            rr_ff <= 2'h0;
            ctrl_ff <= CTRL_RESET;
            imask_ff <= 2'h0;
            ist_ff <= 2'h0;
        end else begin
            aw_ff <= nxt_aw;
            w_ff <= nxt_w;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
            ctrl_ff <= nxt_ctrl;
            imask_ff <= nxt_imask;
            ist_ff <= nxt_ist;
        end
    end

    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = br_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rd_ff;
    assign s_axi_rresp = rr_ff;
    assign irq = |(ist_ff & imask_ff);
endmodule : hrm_monitor

// File: src/hrm_pkg.sv
// Shared constants for the holdover reference monitor.
package hrm_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Extra time allowed on top of the crystal-period terms.
    localparam int unsigned EDGE_EXTRA_NS = 25;
    // Longest time rounds down, least time rounds up.
    localparam int unsigned FAIL_EXTRA_CYC =
        (EDGE_EXTRA_NS / CLK_PERIOD_NS) < 1 ? 1 :
        EDGE_EXTRA_NS / CLK_PERIOD_NS;
    localparam int unsigned REC_EXTRA_CYC =
        (EDGE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Crystal periods figures of the assert and recovery delays.
    localparam int unsigned FAIL_XTAL_PERIODS = 2;
    localparam int unsigned REC_XTAL_PERIODS = 12;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_TUNE = 8'h10;

    localparam int unsigned CTRL_CHOICE_BIT = 0;
    localparam int unsigned CTRL_RATIO_LSB = 1;
    localparam logic [2:0] CTRL_RESET = 3'h5;
    localparam int unsigned STAT_VALID_BIT = 0;
    localparam int unsigned STAT_BYPASS_BIT = 1;
    localparam int unsigned IRQ_FAIL_BIT = 0;
    localparam int unsigned IRQ_RECOVER_BIT = 1;
    localparam int unsigned TUNE_W = 8;
    localparam logic [7:0] TUNE_RESET = 8'h80;

    localparam logic [1:0] RATIO_BYPASS = 2'h0;
    localparam logic [1:0] RATIO_HALF = 2'h1;
    localparam logic [1:0] RATIO_TWO = 2'h2;
    localparam logic [1:0] RATIO_SIX = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        HRM_VALID,
        HRM_FAILED,
        HRM_RECOVER,
        HRM_SETTLE
    } hrm_state_e;
endpackage : hrm_pkg

// File: src/hrm_sync3.sv
// Three-flop pin synchroniser with agreement filter and rise pulse.
`timescale 1ns/1ns
module hrm_sync3 #(
    parameter int W = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
    logic [W-1:0] nxt_out;

    // A change counts only once the second and third stages agree.
    always_comb begin
        nxt_out = out_ff;
        for (int i = 0; i < W; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                nxt_out[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            out_ff <= '0;
        end else begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
        end
    end

    assign level = out_ff;
    assign rise = nxt_out & ~out_ff;
endmodule : hrm_sync3

// File: tb/hrm_refsrc.sv
// Behavioural reference and crystal sources facing the monitor.
`timescale 1ns/1ns
module hrm_refsrc
    import hrm_pkg::*;
(
    input wire logic aclk,
    input wire logic run_a,
    input wire logic run_b,
    input wire logic [1:0] ratio,
    output logic ref_a_in,
    output logic ref_b_in,
    output logic crystal_in,
    output logic pll_clk_in
);
    logic [5:0] xc = 6'h00;
    logic [5:0] rc = 6'h00;
    logic [5:0] half;
    // Crystal period is 48 cycles; references run at ratio times that.
    assign half = (ratio == RATIO_HALF) ? 6'h2f :
        (ratio == RATIO_SIX) ? 6'h03 : 6'h0b;
    initial begin
        ref_a_in = 1'b0;
        ref_b_in = 1'b0;
        crystal_in = 1'b0;
        pll_clk_in = 1'b0;
    end
    always @(posedge aclk) begin
        pll_clk_in <= !pll_clk_in;
        xc <= (xc == 6'h17) ? 6'h00 : xc + 6'h01;
        if (xc == 6'h17) crystal_in <= !crystal_in;
        rc <= (rc >= half) ? 6'h00 : rc + 6'h01;
        // A stopped source holds its last level, as a dead oscillator does.
        if (rc >= half && run_a) ref_a_in <= !ref_a_in;
        if (rc >= half && run_b) ref_b_in <= !ref_b_in;
    end
endmodule : hrm_refsrc

// File: tb/hrm_monitor_props.sv
// Port-level assertions for the holdover reference monitor.
`timescale 1ns/1ns
module hrm_monitor_props
    import hrm_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic crystal_in,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pll_ref_out,
    input wire logic ref_valid,
    input wire logic [TUNE_W-1:0] tune_word
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_xtal_pll_hi: assert property (crystal_in [*8] |-> pll_ref_out)
        else $error("PLL input not high with crystal");
    a_xtal_pll_lo: assert property (!crystal_in [*8] |-> !pll_ref_out)
        else $error("PLL input not low with crystal");
    a_tune_frozen: assert property (!ref_valid |-> $stable(tune_word))
        else $error("tuning moved while reference failed");
    a_fail_holds: assert property ($fell(ref_valid) |=> !ref_valid [*8])
        else $error("valid flag recovered too soon");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during response");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during response");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    cover property ($fell(ref_valid));
    cover property ($rose(ref_valid));
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : hrm_monitor_props

bind hrm_monitor hrm_monitor_props hrm_monitor_props_i (.*);

// File: tb/tb.sv
// Register-level testbench for the holdover reference monitor.
`timescale 1ns/1ns
module tb
    import hrm_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic run_a = 1'b1;
    logic run_b = 1'b0;
    logic [1:0] src_ratio = RATIO_TWO;
    logic ref_a_in, ref_b_in, crystal_in, pll_clk_in;
    logic [31:0] s_axi_awaddr = 32'h0000_0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_araddr = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, pll_ref_out, ref_valid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, bank_a_outputs, bank_b_outputs;
    logic [31:0] s_axi_rdata, rv, t;
    logic [TUNE_W-1:0] tune_word;
    logic [1:0] resp;
    int error_cnt = 0;
    int num_checks = 0;
    int wn;
    // Crystal period that the source model makes, in nanoseconds.
    localparam int XTAL_NS = 384;
    localparam int REC_MIN_NS = REC_XTAL_PERIODS * XTAL_NS + EDGE_EXTRA_NS;
    hrm_monitor hrm_monitor_i (.*);
    hrm_refsrc hrm_refsrc_i (.aclk(aclk), .run_a(run_a), .run_b(run_b),
        .ratio(src_ratio), .ref_a_in(ref_a_in), .ref_b_in(ref_b_in),
        .crystal_in(crystal_in), .pll_clk_in(pll_clk_in));
    initial forever #4 aclk = ~aclk;
    task automatic end_of_test;
        if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic hang;
        error_cnt++;
        end_of_test();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {24'h00_0000, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Ready trails the response by a cycle, so a held response is seen.
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 64) hang();
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {24'h00_0000, a};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 64) hang();
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rv, exp);
    endtask : rd_chk
    task automatic ctl(input logic [1:0] r, input logic c);
        wr(ADDR_CTRL, {29'h0000_0000, r, c});
    endtask : ctl
    // Waits for the valid flag; running out of the bound ends the run.
    task automatic wait_v(input logic lvl, input int bound);
        for (wn = 0; wn < bound && ref_valid !== lvl; wn++) @(posedge aclk);
        if (wn == bound) hang();
        chk({31'h0000_0000, ref_valid}, {31'h0000_0000, lvl});
    endtask : wait_v
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk({31'h0000_0000, ref_valid}, 32'h0000_0000);
        rd_chk(ADDR_CTRL, {29'h0000_0000, CTRL_RESET});
        rd_chk(ADDR_TUNE, {24'h00_0000, TUNE_RESET});
        rd_chk(ADDR_IRQ_MASK, 32'h0000_0000);
        rd(8'h20);
        chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
        wr(8'h24, 32'h0000_0001);
        chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
        for (int i = 1; i < 4; i++) begin
            src_ratio <= 2'(i);
            ctl(2'(i), 1'b1);
            // A whole window at the new ratio is judged before the wait.
            repeat (1600) @(posedge aclk);
            wait_v(1'b1, 4000);
            rd_chk(ADDR_STATUS, 32'h0000_0001);
            #1 chk({30'h0000_0000, bank_a_outputs}, {30'h0, {2{!pll_clk_in}}});
        end
        src_ratio <= RATIO_TWO;
        wait_v(1'b0, 3000);
        ctl(RATIO_TWO, 1'b1);
        wait_v(1'b1, 4000);
        wr(ADDR_IRQ_STAT, 32'h0000_0003);
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY});
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        run_a <= 1'b0;
        wait_v(1'b0, 120);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0001);
        rd(ADDR_TUNE);
        t = rv;
        repeat (800) @(posedge aclk);
        rd_chk(ADDR_TUNE, t);
        wr(ADDR_IRQ_STAT, 32'h0000_0001);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        run_a <= 1'b1;
        wait_v(1'b1, 4000);
        chk(32'(wn * CLK_PERIOD_NS > REC_MIN_NS), 32'h0000_0001);
        rd_chk(ADDR_IRQ_STAT, 32'h0000_0002);
        #1 chk({31'h0000_0000, irq}, 32'h0000_0000);
        ctl(RATIO_TWO, 1'b0);
        wait_v(1'b0, 120);
        run_b <= 1'b1;
        wait_v(1'b1, 4000);
        run_a <= 1'b0;
        repeat (300) @(posedge aclk);
        chk({31'h0000_0000, ref_valid}, 32'h0000_0001);
        ctl(RATIO_BYPASS, 1'b0);
        rd(ADDR_STATUS);
        chk(rv & 32'h0000_0002, 32'h0000_0002);
        run_b <= 1'b0;
        repeat (10) @(posedge aclk);
        #1 chk({30'h0000_0000, bank_a_outputs}, {30'h0, {2{ref_b_in}}});
        chk({30'h0000_0000, bank_b_outputs}, {30'h0, {2{ref_b_in}}});
        // Let the second reference toggle exactly once, then look again.
        run_b <= 1'b1;
        repeat (12) @(posedge aclk);
        run_b <= 1'b0;
        repeat (10) @(posedge aclk);
        #1 chk({30'h0000_0000, bank_a_outputs}, {30'h0, {2{ref_b_in}}});
        chk({30'h0000_0000, bank_b_outputs}, {30'h0, {2{ref_b_in}}});
        end_of_test();
    end
endmodule : tb
